// ### dpr_pkg.sv
// package for the dram strobe controller: timing counts, geometry, commands
// assumes a 10 MHz system clock driving the controller
package dpr_pkg;
	localparam int unsigned CLK_NS             = 100;
	localparam int unsigned ROW_BITS           = 10;
	localparam int unsigned COL_BITS           = 10;
	localparam int unsigned DATA_BITS          = 4;
	localparam int unsigned ROW_COUNT          = 1024;
	localparam int unsigned INIT_CYCLES        = 8;
	localparam int unsigned POWERUP_US         = 200;
	localparam int unsigned REFRESH_PERIOD_MS  = 16;
	localparam int unsigned REFRESH_INTERVAL_NS = 15600;
	localparam int unsigned COLUMN_PRECHARGE_NS = 10;
	localparam int unsigned ROW_PRECHARGE_NS   = 55;
	localparam int unsigned ROW_ACTIVE_NS      = 85;
	localparam int unsigned PAGE_MAX_ACTIVE_NS = 200000;
	localparam int unsigned WRITE_SETUP_NS     = 10;
	localparam int unsigned WRITE_HOLD_NS      = 10;
	// least times round up, longest round down, all at least one cycle
	function automatic int unsigned cyc_min(input int unsigned ns);
		int unsigned c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction
	function automatic int unsigned cyc_max(input int unsigned ns);
		int unsigned c;
		c = ns / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int unsigned POWERUP_CYC     = cyc_min(POWERUP_US * 1000);
	localparam int unsigned REFRESH_CYC     = cyc_max(REFRESH_INTERVAL_NS);
	localparam int unsigned COL_PRE_CYC     = cyc_min(COLUMN_PRECHARGE_NS);
	localparam int unsigned ROW_PRE_CYC     = cyc_min(ROW_PRECHARGE_NS);
	localparam int unsigned ROW_ACT_CYC     = cyc_min(ROW_ACTIVE_NS);
	localparam int unsigned PAGE_MAX_CYC    = cyc_max(PAGE_MAX_ACTIVE_NS);
	localparam int unsigned WR_SETUP_CYC    = cyc_min(WRITE_SETUP_NS);
	localparam int unsigned WR_HOLD_CYC     = cyc_min(WRITE_HOLD_NS);
	// request opcodes and refresh kinds
	localparam logic [2:0] OP_READ      = 3'h0;
	localparam logic [2:0] OP_WRITE     = 3'h1;
	localparam logic [2:0] OP_RMW       = 3'h2;
	localparam logic [2:0] OP_CTR_TEST  = 3'h3;
	localparam logic [2:0] OP_TEST_ENTER = 3'h4;
	localparam logic [2:0] OP_TEST_EXIT = 3'h5;
	localparam logic [2:0] OP_HIDDEN    = 3'h6;
	localparam logic [1:0] RF_NONE      = 2'h0;
	localparam logic [1:0] RF_ROW_ONLY  = 2'h1;
	localparam logic [1:0] RF_CBR       = 2'h2;
	localparam logic [1:0] RF_CBR_WRITE = 2'h3;
endpackage

// ### dpr_timer.sv
// down counter used for strobe phase lengths
// assumes loads come one at a time from the strobe sequencer
`timescale 1ns/1ps
`default_nettype none
module dpr_timer #(
	parameter int unsigned WIDTH = 12
) (
	input  wire logic             i_clock,
	input  wire logic             i_reset,
	input  wire logic             i_load,
	input  wire logic [WIDTH-1:0] i_value,
	output logic                  o_done
);
	logic [WIDTH-1:0] count_r;
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			count_r <= '0;
		end else if (i_load) begin
			count_r <= i_value;
		end else if (count_r != '0) begin
			count_r <= count_r - 1'b1;
		end
	end
	// done from the count alone, so callers may reload on done
	assign o_done = (count_r == '0);
endmodule
`default_nettype wire

// ### dpr_ctrl.sv
// dram strobe controller driving a 1M x 4 asynchronous dram
// assumes dram pins sampled/driven on the 10 MHz i_clock
`timescale 1ns/1ps
`default_nettype none
module dpr_ctrl
	import dpr_pkg::*;
#(
	parameter int unsigned POWERUP_CYCLES = POWERUP_CYC,
	parameter int unsigned REFRESH_CYCLES = REFRESH_CYC,
	parameter int unsigned PAGE_MAX_CYCLES = PAGE_MAX_CYC,
	parameter logic        DISTRIBUTED    = 1'b1
) (
	input  wire logic                 i_clock,
	input  wire logic                 i_reset,
	input  wire logic                 i_req_valid,
	input  wire logic [2:0]           i_req_op,
	input  wire logic [ROW_BITS-1:0]  i_req_row,
	input  wire logic [COL_BITS-1:0]  i_req_col,
	input  wire logic [DATA_BITS-1:0] i_req_wdata,
	input  wire logic                 i_req_keep_open,
	output logic                      o_req_ready,
	output logic                      o_rsp_valid,
	output logic [DATA_BITS-1:0]      o_rsp_rdata,
	output logic                      o_init_done,
	output logic                      o_test_mode,
	input  wire logic                 i_idle_expired,
	output logic                      o_row_strobe_n,
	output logic                      o_column_strobe_n,
	output logic                      o_store_select_n,
	output logic                      o_output_enable_n,
	output logic [ROW_BITS-1:0]       o_addr,
	input  wire logic [DATA_BITS-1:0] i_dq,
	output logic [DATA_BITS-1:0]      o_dq,
	output logic                      o_dq_oe
);
	localparam int unsigned TW = 20;

	typedef enum logic [3:0] {
		DPR_IDLE, DPR_POWERUP, DPR_WAKE_LOW, DPR_WAKE_HIGH,
		DPR_ROW_FALL, DPR_COL_FALL, DPR_COL_HOLD, DPR_COL_PRE,
		DPR_CBR_COL, DPR_CBR_ROW, DPR_HID_HIGH, DPR_CLOSE, DPR_PRECH
	} dpr_state_e;

	dpr_state_e            state_r;
	logic                  tload;
	logic [TW-1:0]         tval;
	logic                  tdone;
	logic [3:0]            wake_cnt_r;
	logic [3:0]            cbr_cnt_r;
	logic [ROW_BITS-1:0]   ref_row_r;
	logic [TW-1:0]         ref_tmr_r;
	logic                  ref_due_r;
	logic [TW-1:0]         page_tmr_r;
	logic [1:0]            rf_kind_r;
	logic [2:0]            op_r;
	logic [COL_BITS-1:0]   col_r;
	logic [DATA_BITS-1:0]  wdata_r;
	logic                  keep_r;
	logic [ROW_BITS-1:0]   row_r;

	dpr_timer #(.WIDTH(TW)) u_timer (
		.i_clock (i_clock),
		.i_reset (i_reset),
		.i_load  (tload),
		.i_value (tval),
		.o_done  (tdone)
	);

	function automatic logic is_write(input logic [2:0] op);
		return (op == OP_WRITE);
	endfunction

	wire logic take = o_req_ready && i_req_valid;
	// page can continue if the last request asked to keep it open and the row is still in time
	wire logic page_ok = keep_r && (page_tmr_r < TW'(PAGE_MAX_CYCLES - ROW_ACT_CYC));

	always_comb begin
		tload = 1'b0;
		tval  = '0;
		case (state_r)
			DPR_POWERUP: begin
				tload = (wake_cnt_r == 4'hf);
				tval  = TW'(POWERUP_CYCLES);
			end
			DPR_IDLE: begin
				tload = ref_due_r || take;
				tval  = TW'(WR_SETUP_CYC);
			end
			DPR_ROW_FALL, DPR_CBR_ROW, DPR_WAKE_LOW: begin
				tload = tdone;
				tval  = TW'(ROW_ACT_CYC);
			end
			DPR_COL_FALL, DPR_CBR_COL, DPR_COL_HOLD: begin
				tload = tdone;
				tval  = TW'(COL_PRE_CYC);
			end
			DPR_CLOSE, DPR_HID_HIGH, DPR_WAKE_HIGH: begin
				tload = tdone;
				tval  = TW'(ROW_PRE_CYC);
			end
			default: begin
				tload = 1'b0;
				tval  = '0;
			end
		endcase
	end

	// one refresh per interval when distributed
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			ref_tmr_r <= '0;
			ref_due_r <= 1'b0;
		end else if (!o_init_done) begin
			ref_tmr_r <= '0;
		end else if (ref_tmr_r >= TW'(REFRESH_CYCLES - 1)) begin
			ref_tmr_r <= '0;
			ref_due_r <= 1'b1;
		end else begin
			ref_tmr_r <= ref_tmr_r + 1'b1;
			if (state_r == DPR_CBR_ROW || (state_r == DPR_ROW_FALL && rf_kind_r != RF_NONE))
				ref_due_r <= 1'b0;
		end
	end

	// row active time tracked for page cap
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset)
			page_tmr_r <= '0;
		else if (o_row_strobe_n)
			page_tmr_r <= '0;
		else if (page_tmr_r != '1)
			page_tmr_r <= page_tmr_r + 1'b1;
	end

	// own row counter for row-only refresh
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset)
			ref_row_r <= '0;
		else if (state_r == DPR_ROW_FALL && rf_kind_r == RF_ROW_ONLY && tload)
			ref_row_r <= ref_row_r + 1'b1;
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset)
			cbr_cnt_r <= '0;
		else if (state_r == DPR_CBR_ROW && tload && cbr_cnt_r != 4'(INIT_CYCLES))
			cbr_cnt_r <= cbr_cnt_r + 1'b1;
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset)
			o_test_mode <= 1'b0;
		else if (state_r == DPR_CBR_ROW && tload)
			o_test_mode <= (rf_kind_r == RF_CBR_WRITE) ? 1'b1 :
				(rf_kind_r == RF_CBR ? 1'b0 : o_test_mode);
		else if (state_r == DPR_ROW_FALL && tload && rf_kind_r == RF_ROW_ONLY)
			o_test_mode <= 1'b0;
	end

	// main sequencer
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			state_r           <= DPR_POWERUP;
			o_row_strobe_n    <= 1'b1;
			o_column_strobe_n <= 1'b1;
			o_store_select_n  <= 1'b1;
			o_output_enable_n <= 1'b1;
			o_addr            <= '0;
			o_dq              <= '0;
			o_dq_oe           <= 1'b0;
			o_req_ready       <= 1'b0;
			o_rsp_valid       <= 1'b0;
			o_rsp_rdata       <= '0;
			o_init_done       <= 1'b0;
			// all ones marks the pause not yet loaded
			wake_cnt_r        <= 4'hf;
			row_r             <= '0;
			rf_kind_r         <= RF_NONE;
			op_r              <= OP_READ;
			col_r             <= '0;
			wdata_r           <= '0;
			keep_r            <= 1'b0;
		end else begin
			o_rsp_valid <= 1'b0;
			case (state_r)
				// power-up pause then eight row cycles
				DPR_POWERUP: begin
					wake_cnt_r <= '0;
					if (wake_cnt_r == '0 && tdone)
						state_r <= DPR_WAKE_HIGH;
				end
				DPR_WAKE_HIGH: begin
					o_row_strobe_n <= 1'b1;
					if (tdone) begin
						o_row_strobe_n <= 1'b0;
						state_r        <= DPR_WAKE_LOW;
					end
				end
				DPR_WAKE_LOW: begin
					if (tdone) begin
						o_row_strobe_n <= 1'b1;
						wake_cnt_r     <= wake_cnt_r + 1'b1;
						if (wake_cnt_r == 4'(INIT_CYCLES - 1)) begin
							state_r     <= DPR_PRECH;
							o_init_done <= 1'b1;
						end else begin
							state_r <= DPR_WAKE_HIGH;
						end
					end
				end
				DPR_IDLE: begin
					o_req_ready <= 1'b0;
					// a shown ready is always honoured before refresh or wake
					if (i_idle_expired && !take) begin
						wake_cnt_r  <= '0;
						o_init_done <= 1'b0;
						state_r     <= DPR_WAKE_HIGH;
					end else if (ref_due_r && !take) begin
						rf_kind_r <= o_test_mode ? RF_CBR_WRITE :
							(DISTRIBUTED ? RF_CBR : RF_ROW_ONLY);
						if (!o_test_mode && !DISTRIBUTED) begin
							// row-only refresh with column strobe high
							o_addr         <= ref_row_r;
							o_row_strobe_n <= 1'b0;
							state_r        <= DPR_ROW_FALL;
						end else begin
							// store select high around row fall unless in test mode
							o_store_select_n  <= !o_test_mode;
							o_column_strobe_n <= 1'b0;
							state_r           <= DPR_CBR_COL;
						end
					end else if (take) begin
						op_r    <= i_req_op;
						col_r   <= i_req_col;
						wdata_r <= i_req_wdata;
						keep_r  <= i_req_keep_open;
						row_r   <= i_req_row;
						rf_kind_r <= RF_NONE;
						if (i_req_op == OP_TEST_ENTER || i_req_op == OP_TEST_EXIT) begin
							// enter with store select low, exit with plain refresh
							rf_kind_r         <= (i_req_op == OP_TEST_ENTER) ? RF_CBR_WRITE : RF_CBR;
							o_store_select_n  <= (i_req_op != OP_TEST_ENTER);
							o_column_strobe_n <= 1'b0;
							state_r           <= DPR_CBR_COL;
						end else if (i_req_op == OP_CTR_TEST && cbr_cnt_r == 4'(INIT_CYCLES)) begin
							// counter test; column strobe first, store select held high
							// allowed only after eight CBR row cycles have been counted
							o_column_strobe_n <= 1'b0;
							o_store_select_n  <= 1'b1;
							o_output_enable_n <= 1'b0;
							o_addr            <= i_req_col;
							keep_r            <= 1'b0;
							state_r           <= DPR_CBR_COL;
						end else if (i_req_op == OP_CTR_TEST || i_req_op == OP_HIDDEN) begin
							o_rsp_valid <= 1'b1;
							state_r     <= DPR_PRECH;
						end else begin
							// normal access latches and refreshes the row
							o_addr         <= i_req_row;
							o_row_strobe_n <= 1'b0;
							state_r        <= DPR_ROW_FALL;
						end
					end else begin
						o_req_ready <= 1'b1;
					end
				end
				DPR_ROW_FALL: begin
					if (tdone) begin
						if (rf_kind_r != RF_NONE) begin
							o_row_strobe_n <= 1'b1;
							rf_kind_r      <= RF_NONE;
							state_r        <= DPR_PRECH;
						end else begin
							// low column bit ignored by device in test mode
							o_addr            <= col_r;
							// store select set on the same edge as column fall
							o_store_select_n  <= !is_write(op_r);
							o_output_enable_n <= is_write(op_r);
							o_dq              <= wdata_r;
							o_dq_oe           <= is_write(op_r);
							o_column_strobe_n <= 1'b0;
							state_r           <= DPR_COL_FALL;
						end
					end
				end
				// column latched at the column strobe fall
				DPR_COL_FALL: begin
					if (tdone) begin
						if (op_r == OP_RMW && o_store_select_n) begin
							// read then write on same column
							o_rsp_rdata      <= i_dq;
							o_output_enable_n <= 1'b1;
							o_dq             <= wdata_r;
							o_dq_oe          <= 1'b1;
							o_store_select_n <= 1'b0;
						end else begin
							// in test mode this is the block compare result
							if (op_r != OP_WRITE && o_store_select_n)
								o_rsp_rdata <= i_dq;
							o_rsp_valid <= 1'b1;
							state_r     <= DPR_COL_HOLD;
						end
					end
				end
				DPR_COL_HOLD: begin
					// raise column strobe for precharge with row held low
					o_column_strobe_n <= 1'b1;
					o_store_select_n  <= 1'b1;
					o_output_enable_n <= 1'b1;
					o_dq_oe           <= 1'b0;
					state_r           <= DPR_COL_PRE;
				end
				DPR_COL_PRE: begin
					o_req_ready <= 1'b0;
					if (tdone && i_req_valid && !o_req_ready && page_ok && !ref_due_r
						&& i_req_row == row_r && i_req_op <= OP_RMW) begin
						o_req_ready <= 1'b1;
					end else if (o_req_ready && i_req_valid) begin
						// next page cycle, read, write or read-write only
						op_r              <= i_req_op;
						keep_r            <= i_req_keep_open;
						o_addr            <= i_req_col;
						wdata_r           <= i_req_wdata;
						o_store_select_n  <= !is_write(i_req_op);
						o_output_enable_n <= is_write(i_req_op);
						o_dq              <= i_req_wdata;
						o_dq_oe           <= is_write(i_req_op);
						o_column_strobe_n <= 1'b0;
						o_req_ready       <= 1'b0;
						state_r           <= DPR_COL_FALL;
					end else if (tdone) begin
						// row strobe rises after column strobe is already high
						o_row_strobe_n <= 1'b1;
						state_r        <= DPR_PRECH;
					end
				end
				// device row from internal counter, address used only as column in counter test
				DPR_CBR_COL: begin
					if (tdone) begin
						o_row_strobe_n <= 1'b0;
						state_r        <= DPR_CBR_ROW;
					end
				end
				// output enable raised for the counter test write, else left as it was
				DPR_CBR_ROW: begin
					if (tdone) begin
						if (op_r == OP_CTR_TEST && rf_kind_r == RF_NONE) begin
							o_rsp_rdata       <= i_dq;
							o_addr            <= col_r;
							o_output_enable_n <= 1'b1;
							o_dq              <= wdata_r;
							o_dq_oe           <= 1'b1;
							o_store_select_n  <= 1'b0;
							op_r              <= OP_WRITE;
							state_r           <= DPR_COL_FALL;
						end else begin
							o_store_select_n <= 1'b1;
							o_row_strobe_n   <= 1'b1;
							rf_kind_r        <= RF_NONE;
							state_r          <= (op_r == OP_TEST_ENTER || op_r == OP_TEST_EXIT)
								? DPR_CLOSE : DPR_HID_HIGH;
						end
					end
				end
				// end of CBR refresh: column strobe held low while row strobe precharges
				DPR_HID_HIGH: begin
					if (tdone) begin
						o_column_strobe_n <= 1'b1;
						state_r           <= DPR_PRECH;
					end
				end
				DPR_CLOSE: begin
					if (tdone) begin
						o_column_strobe_n <= 1'b1;
						o_rsp_valid       <= 1'b1;
						state_r           <= DPR_PRECH;
					end
				end
				DPR_PRECH: begin
					o_column_strobe_n <= 1'b1;
					o_row_strobe_n    <= 1'b1;
					o_dq_oe           <= 1'b0;
					op_r              <= OP_READ;
					state_r           <= DPR_IDLE;
				end
				default: state_r <= DPR_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### dpr_dram_model.sv
// behavioural 1M x 4 dram answering the strobe controller
// assumes strobes move only on controller clock edges
`timescale 1ns/1ps
`default_nettype none
module dpr_dram_model
	import dpr_pkg::*;
(
	input  wire logic                 i_row_strobe_n,
	input  wire logic                 i_column_strobe_n,
	input  wire logic                 i_store_select_n,
	input  wire logic                 i_output_enable_n,
	input  wire logic [ROW_BITS-1:0]  i_addr,
	input  wire logic [DATA_BITS-1:0] i_dq,
	output logic      [DATA_BITS-1:0] o_dq,
	output logic                      o_test_mode,
	output logic      [ROW_BITS-1:0]  o_ref_row
);
	bit   [DATA_BITS-1:0] mem [0:(1 << (ROW_BITS + COL_BITS)) - 1];
	logic [ROW_BITS-1:0]  row;
	logic [COL_BITS-1:0]  col;
	logic [DATA_BITS-1:0] q;
	logic                 cas_seen;
	initial begin
		o_test_mode = 1'b0;
		o_ref_row = '0;
		row = '0;
		col = '0;
		q = '0;
		cas_seen = 1'b0;
	end
	function automatic logic [DATA_BITS-1:0] rd(input logic [COL_BITS-1:0] c);
		return mem[{row, c}];
	endfunction
	// whole row kept, pair written in test
	task automatic wr;
		if (o_test_mode) begin
			mem[{row, col[9:1], 1'b0}] = i_dq;
			mem[{row, col[9:1], 1'b1}] = i_dq;
		end else begin
			mem[{row, col}] = i_dq;
		end
	endtask
	always @(negedge i_row_strobe_n) begin
		cas_seen = !i_column_strobe_n;
		if (!i_column_strobe_n) begin
			row = o_ref_row;
			// counter test: external column, read when output enabled
			col = i_addr;
			if (!i_output_enable_n)
				q = rd(col);
			o_ref_row = o_ref_row + 10'h001;
			o_test_mode = !i_store_select_n;
		end else begin
			row = i_addr;
		end
	end
	always @(posedge i_row_strobe_n) begin
		if (!cas_seen)
			o_test_mode = 1'b0;
	end
	// column select, compare output in test
	always @(negedge i_column_strobe_n) begin
		// let address and data driven on the same edge settle
		#1;
		if (!i_row_strobe_n) begin
			cas_seen = 1'b1;
			col = o_test_mode ? {i_addr[9:1], 1'b0} : i_addr;
			if (!i_store_select_n)
				wr();
			else
				q = o_test_mode ? {4{rd(col) === rd(col | 10'h001)}} : rd(col);
		end
	end
	// late write of a read-write cycle
	always @(negedge i_store_select_n) begin
		#1;
		if (!i_row_strobe_n && !i_column_strobe_n)
			wr();
	end
	// output held while column strobe stays low
	assign o_dq = (!i_column_strobe_n && !i_output_enable_n && i_store_select_n) ? q : ~q;
endmodule
`default_nettype wire

// ### dpr_ctrl_chk.sv
// port checker for the dram strobe controller
// assumes bind onto dpr_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
module dpr_ctrl_chk
	import dpr_pkg::*;
#(
	parameter int unsigned REFRESH_CYCLES  = 156,
	parameter int unsigned PAGE_MAX_CYCLES = 2000
) (
	input wire logic       i_clock,
	input wire logic       i_reset,
	input wire logic       i_req_valid,
	input wire logic [2:0] i_req_op,
	input wire logic       o_req_ready,
	input wire logic       o_rsp_valid,
	input wire logic       o_init_done,
	input wire logic       o_test_mode,
	input wire logic       o_row_strobe_n,
	input wire logic       o_column_strobe_n,
	input wire logic       o_store_select_n,
	input wire logic       o_dq_oe
);
	localparam int unsigned REF_LIMIT = REFRESH_CYCLES + 150;
	logic [3:0]  falls_r;
	logic [15:0] gap_r;
	logic [15:0] low_r;
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_reset);
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset)
			falls_r <= 4'h0;
		else if ($fell(o_row_strobe_n) && falls_r != 4'hf)
			falls_r <= falls_r + 4'h1;
	end
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset)
			gap_r <= 16'h0000;
		else if (!o_init_done || ($fell(o_row_strobe_n) && !o_column_strobe_n))
			gap_r <= 16'h0000;
		else if (gap_r != 16'hffff)
			gap_r <= gap_r + 16'h0001;
	end
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset)
			low_r <= 16'h0000;
		else if (o_row_strobe_n)
			low_r <= 16'h0000;
		else if (low_r != 16'hffff)
			low_r <= low_r + 16'h0001;
	end
	a_init_order: assert property ($rose(o_init_done) |-> falls_r >= 4'h8)
		else $error("init done before eight row cycles");
	a_ready_init: assert property (!o_init_done |-> !o_req_ready)
		else $error("ready before init");
	a_take_busy: assert property (o_req_ready && i_req_valid && i_req_op <= OP_RMW |=> !o_req_ready)
		else $error("ready stayed high after take");
	a_cbr_hold: assert property ($fell(o_row_strobe_n) && !o_column_strobe_n && o_store_select_n
		|-> $past(o_store_select_n) ##1 o_store_select_n) else $error("store select not held around refresh");
	a_test_entry: assert property ($fell(o_row_strobe_n) && !o_column_strobe_n && !o_store_select_n
		|-> ##[0:20] o_test_mode) else $error("test mode flag missing");
	a_page_max: assert property (low_r <= PAGE_MAX_CYCLES)
		else $error("row strobe low too long");
	a_refresh_gap: assert property (o_init_done |-> gap_r <= REF_LIMIT)
		else $error("refresh interval exceeded");
	a_early_write: assert property ($fell(o_column_strobe_n) && !o_row_strobe_n && !o_store_select_n
		|-> o_dq_oe) else $error("early write without data");
	a_read_sel: assert property (o_req_ready && i_req_valid && i_req_op == OP_READ
		|-> ##[1:20] ($fell(o_column_strobe_n) && o_store_select_n)) else $error("read column fall missing");
	a_rsp_pulse: assert property (o_rsp_valid |=> !o_rsp_valid)
		else $error("response longer than one cycle");
	c_page: cover property ($rose(o_column_strobe_n) && !o_row_strobe_n ##[1:3] $fell(o_column_strobe_n));
	c_test: cover property ($rose(o_test_mode));
	c_cbr: cover property ($fell(o_row_strobe_n) && !o_column_strobe_n);
endmodule
`default_nettype wire

// ### dpr_ctrl_bench.sv
// self-checking bench for the dram strobe controller
// assumes dpr_dram_model on the far side
`timescale 1ns/1ps
`default_nettype none
module dpr_ctrl_bench
	import dpr_pkg::*;
;
	localparam int unsigned RC = 60;
	logic       clk, rst, vld, keep, ready, rsp, idone, tmode, ras_n, cas_n, ss_n, oe_n, dq_oe, mtm;
	logic [2:0] op;
	logic [9:0] row, col, addr, mref, cref;
	logic [3:0] wd, rdata, c_dq, m_dq, dq_w, got;
	int         err_total, n_tests;
	int         cyc = 0;
	assign dq_w = dq_oe ? c_dq : m_dq;
	dpr_ctrl #(.POWERUP_CYCLES(20), .REFRESH_CYCLES(RC), .PAGE_MAX_CYCLES(100), .DISTRIBUTED(1'b1)) u_dpr_ctrl (
		.i_clock(clk), .i_reset(rst), .i_req_valid(vld), .i_req_op(op), .i_req_row(row), .i_req_col(col),
		.i_req_wdata(wd), .i_req_keep_open(keep), .o_req_ready(ready), .o_rsp_valid(rsp), .o_rsp_rdata(rdata),
		.o_init_done(idone), .o_test_mode(tmode), .i_idle_expired(1'b0), .o_row_strobe_n(ras_n),
		.o_column_strobe_n(cas_n), .o_store_select_n(ss_n), .o_output_enable_n(oe_n), .o_addr(addr),
		.i_dq(dq_w), .o_dq(c_dq), .o_dq_oe(dq_oe));
	dpr_dram_model u_dpr_dram_model (.i_row_strobe_n(ras_n), .i_column_strobe_n(cas_n), .i_store_select_n(ss_n),
		.i_output_enable_n(oe_n), .i_addr(addr), .i_dq(dq_w), .o_dq(m_dq), .o_test_mode(mtm), .o_ref_row(mref));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_total++;
			test_done();
		end
	end
	task automatic chk_data(input string nm, input logic [3:0] e, input logic [3:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_flag(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (ready !== 1'b1 && n < 3000);
	endtask
	task automatic req(input logic [2:0] o, input logic [9:0] r, input logic [9:0] c, input logic [3:0] d,
			input logic k, input logic want);
		int n;
		@(posedge clk);
		vld <= 1'b1;
		op <= o;
		row <= r;
		col <= c;
		wd <= d;
		keep <= k;
		wait_ready();
		@(posedge clk);
		vld <= 1'b0;
		if (want) begin
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while (rsp !== 1'b1 && n < 100);
			chk_flag("response", 1'b1, rsp);
			got = rdata;
			cref = mref - 10'h001;
		end
	endtask
	task automatic t_init;
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (idone !== 1'b1 && n < 500);
		chk_flag("init done", 1'b1, idone);
		chk_flag("power-up pause", 1'b1, n >= 20 + 2 * INIT_CYCLES);
		$display("test init done");
	endtask
	task automatic t_page;
		req(OP_WRITE, 10'h003, 10'h00a, 4'ha, 1'b1, 1'b1);
		req(OP_WRITE, 10'h003, 10'h00b, 4'h5, 1'b1, 1'b1);
		req(OP_READ, 10'h003, 10'h00a, 4'h0, 1'b1, 1'b1);
		chk_data("page read first", 4'ha, got);
		req(OP_READ, 10'h003, 10'h00b, 4'h0, 1'b0, 1'b1);
		chk_data("page read second", 4'h5, got);
		req(OP_WRITE, 10'h3ff, 10'h3ff, 4'hc, 1'b0, 1'b1);
		req(OP_READ, 10'h3ff, 10'h3ff, 4'h0, 1'b0, 1'b1);
		chk_data("corner cell", 4'hc, got);
		$display("test page done");
	endtask
	task automatic t_rmw;
		req(OP_RMW, 10'h003, 10'h00a, 4'h6, 1'b0, 1'b1);
		chk_data("rmw old data", 4'ha, got);
		req(OP_HIDDEN, 10'h003, 10'h00a, 4'h0, 1'b0, 1'b0);
		wait_ready();
		req(OP_READ, 10'h003, 10'h00a, 4'h0, 1'b0, 1'b1);
		chk_data("rmw new data", 4'h6, got);
		$display("test rmw done");
	endtask
	task automatic t_refresh;
		logic [9:0] r0, d;
		r0 = mref;
		repeat (10 * RC) @(negedge clk);
		d = mref - r0;
		chk_flag("refresh rate", 1'b1, d >= 10'h009 && d <= 10'h00b);
		chk_flag("all rows in period", 1'b1, ROW_COUNT * 10 * RC * CLK_NS <= REFRESH_PERIOD_MS * 1000000 * d);
		$display("test refresh done");
	endtask
	task automatic t_ctr;
		logic [9:0] r;
		req(OP_CTR_TEST, 10'h000, 10'h014, 4'hf, 1'b0, 1'b1);
		chk_data("counter test old", 4'h0, got);
		r = cref;
		req(OP_READ, r, 10'h014, 4'h0, 1'b0, 1'b1);
		chk_data("counter test cell", 4'hf, got);
		$display("test counter done");
	endtask
	task automatic t_test;
		req(OP_TEST_ENTER, 10'h000, 10'h000, 4'h0, 1'b0, 1'b0);
		wait_ready();
		chk_flag("test flag", 1'b1, tmode);
		chk_flag("device test", 1'b1, mtm);
		req(OP_WRITE, 10'h005, 10'h005, 4'h9, 1'b0, 1'b1);
		req(OP_READ, 10'h005, 10'h004, 4'h0, 1'b0, 1'b1);
		chk_data("test compare", 4'hf, got);
		repeat (2 * RC) @(negedge clk);
		chk_flag("test kept by refresh", 1'b1, mtm);
		req(OP_TEST_EXIT, 10'h000, 10'h000, 4'h0, 1'b0, 1'b0);
		wait_ready();
		chk_flag("test flag off", 1'b0, tmode);
		chk_flag("device normal", 1'b0, mtm);
		req(OP_READ, 10'h005, 10'h004, 4'h0, 1'b0, 1'b1);
		chk_data("paired cell", 4'h9, got);
		$display("test mode done");
	endtask
	initial begin
		rst = 1'b1;
		vld = 1'b0;
		op = 3'h0;
		row = 10'h000;
		col = 10'h000;
		wd = 4'h0;
		keep = 1'b0;
		err_total = 0;
		n_tests = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_init();
		t_page();
		t_rmw();
		t_refresh();
		t_ctr();
		t_test();
		test_done();
	end
endmodule
bind dpr_ctrl dpr_ctrl_chk #(.REFRESH_CYCLES(REFRESH_CYCLES), .PAGE_MAX_CYCLES(PAGE_MAX_CYCLES)) u_dpr_ctrl_chk (
	.i_clock(i_clock), .i_reset(i_reset), .i_req_valid(i_req_valid), .i_req_op(i_req_op),
	.o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_init_done(o_init_done), .o_test_mode(o_test_mode),
	.o_row_strobe_n(o_row_strobe_n), .o_column_strobe_n(o_column_strobe_n), .o_store_select_n(o_store_select_n),
	.o_dq_oe(o_dq_oe));
`default_nettype wire
